// file: verilog/flash_erase_cfg.svh
// Opcodes, field positions, reset values and timing counts of the erase link
`ifndef FLASH_ERASE_CFG_SVH
`define FLASH_ERASE_CFG_SVH

`define OP_WRITE_ENABLE 8'h06
`define OP_READ_STATUS 8'h05
`define OP_BLOCK64_ERASE 8'hD8
`define OP_SECTOR_ERASE_WIDE 8'h21
`define OP_HALF_BLOCK_ERASE_WIDE 8'h5C
`define OP_BLOCK64_ERASE_WIDE 8'hDC
`define OP_CHIP_ERASE_A 8'hC7
`define OP_CHIP_ERASE_B 8'h60

`define SECTOR_SHIFT 12
`define HALF_BLOCK_SHIFT 15
`define BLOCK64_SHIFT 16
`define BLOCK_INDEX_MSB 24
`define BLOCK_COUNT 10'd512
`define PROTECT_FULL_LEVEL 4'd10

`define STATUS_WIP_BIT 0
`define STATUS_WEL_BIT 1
`define EXT_ADDR_RESET 8'h00

`define CLK_SYS_MHZ 200
`define SECTOR_ERASE_TIME_US 50
`define HALF_BLOCK_ERASE_TIME_US 200
`define BLOCK64_ERASE_TIME_US 300
`define CHIP_ERASE_TIME_US 1000
`define SECTOR_ERASE_CYC (`SECTOR_ERASE_TIME_US * `CLK_SYS_MHZ)
`define HALF_BLOCK_ERASE_CYC (`HALF_BLOCK_ERASE_TIME_US * `CLK_SYS_MHZ)
`define BLOCK64_ERASE_CYC (`BLOCK64_ERASE_TIME_US * `CLK_SYS_MHZ)
`define CHIP_ERASE_CYC (`CHIP_ERASE_TIME_US * `CLK_SYS_MHZ)

`define SCLK_HALF_CYC 3'd4
`define DESELECT_CYC 4'd8

`endif

// file: verilog/flash_erase_pkg.sv
// Types of the erase link: erase kind and device state for the device end, host state for the host end
`default_nettype none
package flash_erase_pkg;
    typedef enum logic [1:0] {
        KIND_SECTOR = 2'b00,
        KIND_HALF_BLOCK = 2'b01,
        KIND_BLOCK64 = 2'b10,
        KIND_CHIP = 2'b11
    } erase_kind_e;

    typedef enum logic {
        DEV_IDLE = 1'b0,
        DEV_ERASE = 1'b1
    } dev_state_e;

    typedef enum logic [2:0] {
        HOST_IDLE = 3'b000,
        HOST_SELECT = 3'b001,
        HOST_SHIFT = 3'b010,
        HOST_TAIL = 3'b011,
        HOST_GAP = 3'b100
    } host_state_e;
endpackage : flash_erase_pkg
`default_nettype wire

// file: verilog/flash_link_if.sv
// Serial link between the flash host and the flash device
`timescale 1ns/1ps
`default_nettype none
interface flash_link_if;
    logic sclk;
    logic csN;
    logic serialIn;
    logic serialOut;
    logic serialOutEn;

    modport device (
        input sclk,
        input csN,
        input serialIn,
        output serialOut,
        output serialOutEn
    );

    modport host (
        output sclk,
        output csN,
        output serialIn,
        input serialOut,
        input serialOutEn
    );
endinterface : flash_link_if
`default_nettype wire

// file: verilog/flash_erase_device.sv
// Flash device end: command shifter on the link clock, erase sequencer
`timescale 1ns/1ps
`default_nettype none
`include "flash_erase_cfg.svh"
module flash_erase_device
    import flash_erase_pkg::*;
#(
    parameter int unsigned SECTOR_CYC = `SECTOR_ERASE_CYC,
    parameter int unsigned HALF_BLOCK_CYC = `HALF_BLOCK_ERASE_CYC,
    parameter int unsigned BLOCK64_CYC = `BLOCK64_ERASE_CYC,
    parameter int unsigned CHIP_CYC = `CHIP_ERASE_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    flash_link_if.device link,
    input wire logic protect_complement_bit,
    input wire logic protect_top_bottom_bit,
    input wire logic protect_level_bit3,
    input wire logic protect_level_bit2,
    input wire logic protect_level_bit1,
    input wire logic protect_level_bit0,
    input wire logic addr4Mode,
    input wire logic [7:0] extAddr,
    output logic eraseStart,
    output erase_kind_e eraseKind,
    output logic [31:0] eraseBase,
    output logic eraseDone,
    output logic write_in_progress_flag,
    output logic write_enable_latch
);
    // Link clock domain. Deselect only arms a restart: the frame words must
    // survive the select rise until the system side has decoded them.
    logic [6:0] bitCntQ, bitCntD;
    logic [39:0] shiftQ, shiftD;
    logic [7:0] opcodeQ, opcodeD;
    logic [1:0] statSync1Q, statSync2Q;
    logic freshQ;
    logic outBitQ, outBitD;
    logic outEnQ, outEnD;
    logic [7:0] statusByte;

    always_comb begin
        if (freshQ) begin
            bitCntD = 7'h01;
            shiftD = {39'h00_0000_0000, link.serialIn};
            opcodeD = 8'h00;
        end else begin
            bitCntD = (bitCntQ == 7'h7F) ? bitCntQ : bitCntQ + 7'h01;
            shiftD = {shiftQ[38:0], link.serialIn};
            opcodeD = (bitCntQ == 7'h07) ? {shiftQ[6:0], link.serialIn}
                                         : opcodeQ;
        end
    end

    always_ff @(posedge link.sclk) begin
        bitCntQ <= bitCntD;
        shiftQ <= shiftD;
        opcodeQ <= opcodeD;
    end

    always_ff @(posedge link.sclk or posedge link.csN) begin
        if (link.csN) begin
            freshQ <= 1'b1;
            statSync1Q <= 2'b00;
            statSync2Q <= 2'b00;
        end else begin
            freshQ <= 1'b0;
            statSync1Q <= {write_enable_latch, write_in_progress_flag};
            statSync2Q <= statSync1Q;
        end
    end

    always_comb begin
        statusByte = 8'h00;
        statusByte[`STATUS_WEL_BIT] = statSync2Q[1];
        statusByte[`STATUS_WIP_BIT] = statSync2Q[0];
    end

    // Status byte repeats MSB first on falling edges while selected, until the bit count saturates at 127
    always_comb begin
        outEnD = (opcodeQ == `OP_READ_STATUS) && (bitCntQ >= 7'h08);
        outBitD = statusByte[~bitCntQ[2:0]];
    end

    always_ff @(negedge link.sclk or posedge link.csN) begin
        if (link.csN) begin
            outBitQ <= 1'b0;
            outEnQ <= 1'b0;
        end else begin
            outBitQ <= outBitD;
            outEnQ <= outEnD;
        end
    end

    assign link.serialOut = outBitQ;
    assign link.serialOutEn = outEnQ;

    // System clock domain: deselect through two synchronizer flip-flops, edge taken against a third
    logic csSync1Q, csSync2Q, csSync3Q;
    logic frameEnd;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            csSync1Q <= 1'b1;
            csSync2Q <= 1'b1;
            csSync3Q <= 1'b1;
        end else begin
            csSync1Q <= link.csN;
            csSync2Q <= csSync1Q;
            csSync3Q <= csSync2Q;
        end
    end

    // Link clock is stopped while deselected, so frame words are static here
    assign frameEnd = csSync2Q && !csSync3Q;

    function automatic logic [2:0] addrBytes(input logic [7:0] op,
                                              input logic wide);
        unique case (op)
            `OP_BLOCK64_ERASE: addrBytes = wide ? 3'd4 : 3'd3;
            `OP_SECTOR_ERASE_WIDE, `OP_HALF_BLOCK_ERASE_WIDE,
            `OP_BLOCK64_ERASE_WIDE: addrBytes = 3'd4;
            default: addrBytes = 3'd0;
        endcase
    endfunction : addrBytes

    function automatic logic protectedBlock(input logic [8:0] blk,
                                             input logic [5:0] prot);
        logic [9:0] span;
        logic hit;
        span = 10'd0;
        hit = 1'b0;
        if (prot[3:0] >= `PROTECT_FULL_LEVEL) begin
            span = `BLOCK_COUNT;
        end else if (prot[3:0] != 4'd0) begin
            span = 10'd1 << (prot[3:0] - 4'd1);
        end
        if (prot[4]) begin
            hit = {1'b0, blk} < span;
        end else begin
            hit = {1'b0, blk} >= (`BLOCK_COUNT - span);
        end
        protectedBlock = prot[5] ? !hit : hit;
    endfunction : protectedBlock

    logic [5:0] protBits;
    logic anyProtected;
    logic [2:0] needBytes;
    logic [6:0] needBits;
    logic [31:0] frameAddr;
    logic [31:0] regionMask;
    logic isRegionErase, isChipErase;
    logic exactLength;
    logic targetProtected;
    erase_kind_e cmdKind;
    logic [31:0] cmdCycles;

    assign protBits = {protect_complement_bit, protect_top_bottom_bit,
                       protect_level_bit3, protect_level_bit2,
                       protect_level_bit1, protect_level_bit0};

    always_comb begin
        needBytes = addrBytes(opcodeQ, addr4Mode);
        isRegionErase = needBytes != 3'd0;
        isChipErase = (opcodeQ == `OP_CHIP_ERASE_A)
                   || (opcodeQ == `OP_CHIP_ERASE_B);
        needBits = 7'd8 + {1'b0, needBytes, 3'b000};
        exactLength = bitCntQ == needBits;
        if (needBytes == 3'd4) begin
            frameAddr = shiftQ[31:0];
        end else begin
            frameAddr = {extAddr, shiftQ[23:0]};
        end
        cmdKind = KIND_CHIP;
        cmdCycles = CHIP_CYC;
        regionMask = 32'h0000_0000;
        unique case (opcodeQ)
            `OP_SECTOR_ERASE_WIDE: begin
                cmdKind = KIND_SECTOR;
                cmdCycles = SECTOR_CYC;
                regionMask = ~((32'h0000_0001 << `SECTOR_SHIFT) - 32'h1);
            end
            `OP_HALF_BLOCK_ERASE_WIDE: begin
                cmdKind = KIND_HALF_BLOCK;
                cmdCycles = HALF_BLOCK_CYC;
                regionMask = ~((32'h0000_0001 << `HALF_BLOCK_SHIFT) - 32'h1);
            end
            `OP_BLOCK64_ERASE, `OP_BLOCK64_ERASE_WIDE: begin
                cmdKind = KIND_BLOCK64;
                cmdCycles = BLOCK64_CYC;
                regionMask = ~((32'h0000_0001 << `BLOCK64_SHIFT) - 32'h1);
            end
            default: begin
                cmdKind = KIND_CHIP;
                cmdCycles = CHIP_CYC;
                regionMask = 32'h0000_0000;
            end
        endcase
        // Regions never straddle a 64KB block, so one block index suffices
        targetProtected = protectedBlock(
            frameAddr[`BLOCK_INDEX_MSB:`BLOCK64_SHIFT], protBits);
        anyProtected = protBits[5] ? (protBits[3:0] < `PROTECT_FULL_LEVEL)
                                   : (protBits[3:0] != 4'd0);
    end

    // Erase sequencer
    dev_state_e stateQ, stateD;
    logic welQ, welD;
    logic [31:0] timerQ, timerD;
    logic startQ, startD;
    logic doneQ, doneD;
    erase_kind_e kindQ, kindD;
    logic [31:0] baseQ, baseD;
    logic eraseOk;

    always_comb begin
        stateD = stateQ;
        welD = welQ;
        timerD = timerQ;
        startD = 1'b0;
        doneD = 1'b0;
        kindD = kindQ;
        baseD = baseQ;
        eraseOk = 1'b0;
        unique case (stateQ)
            DEV_IDLE: begin
                if (frameEnd && exactLength) begin
                    if (opcodeQ == `OP_WRITE_ENABLE && needBytes == 3'd0) begin
                        welD = 1'b1;
                    end
                    if (isRegionErase) begin
                        eraseOk = welQ && !targetProtected;
                    end else if (isChipErase) begin
                        eraseOk = welQ && !anyProtected;
                    end
                end
                if (eraseOk) begin
                    stateD = DEV_ERASE;
                    welD = 1'b0;
                    timerD = cmdCycles;
                    startD = 1'b1;
                    kindD = cmdKind;
                    baseD = frameAddr & regionMask;
                end
            end
            DEV_ERASE: begin
                // Commands other than status reads are dropped while busy
                if (timerQ <= 32'h0000_0001) begin
                    stateD = DEV_IDLE;
                    doneD = 1'b1;
                    timerD = 32'h0000_0000;
                end else begin
                    timerD = timerQ - 32'h0000_0001;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stateQ <= DEV_IDLE;
            welQ <= 1'b0;
            timerQ <= 32'h0000_0000;
            startQ <= 1'b0;
            doneQ <= 1'b0;
            kindQ <= KIND_SECTOR;
            baseQ <= 32'h0000_0000;
        end else begin
            stateQ <= stateD;
            welQ <= welD;
            timerQ <= timerD;
            startQ <= startD;
            doneQ <= doneD;
            kindQ <= kindD;
            baseQ <= baseD;
        end
    end

    assign eraseStart = startQ;
    assign eraseDone = doneQ;
    assign eraseKind = kindQ;
    assign eraseBase = baseQ;
    assign write_in_progress_flag = stateQ == DEV_ERASE;
    assign write_enable_latch = welQ;
endmodule : flash_erase_device
`default_nettype wire

// file: verilog/flash_erase_host.sv
// Flash host end: frames commands onto the serial link
`timescale 1ns/1ps
`default_nettype none
`include "flash_erase_cfg.svh"
module flash_erase_host
    import flash_erase_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    flash_link_if.host link,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic [7:0] cmdOp,
    input wire logic [31:0] cmdAddr,
    input wire logic [2:0] cmdAddrBytes,
    input wire logic cmdRead,
    output logic [7:0] statusByte,
    output logic statusValid
);
    host_state_e stateQ, stateD;
    logic [2:0] divQ, divD;
    logic [3:0] gapQ, gapD;
    logic sclkQ, sclkD;
    logic csNQ, csND;
    logic [39:0] txQ, txD;
    logic [6:0] bitsLeftQ, bitsLeftD;
    logic [7:0] rxQ, rxD;
    logic readQ, readD;
    logic validQ, validD;
    logic [7:0] statusQ, statusD;
    logic doSync1Q, doSync2Q;
    logic halfDone;

    assign halfDone = divQ == (`SCLK_HALF_CYC - 3'd1);

    always_comb begin
        stateD = stateQ;
        divD = halfDone ? 3'd0 : divQ + 3'd1;
        gapD = gapQ;
        sclkD = sclkQ;
        csND = csNQ;
        txD = txQ;
        bitsLeftD = bitsLeftQ;
        rxD = rxQ;
        readD = readQ;
        validD = 1'b0;
        statusD = statusQ;
        unique case (stateQ)
            HOST_IDLE: begin
                divD = 3'd0;
                if (cmdValid) begin
                    csND = 1'b0;
                    readD = cmdRead;
                    // Address MSB first; three-byte form leaves top byte off
                    unique case (cmdAddrBytes)
                        3'd4: txD = {cmdOp, cmdAddr};
                        3'd3: txD = {cmdOp, cmdAddr[23:0], 8'h00};
                        default: txD = {cmdOp, 32'h0000_0000};
                    endcase
                    bitsLeftD = 7'd8 + {1'b0, cmdAddrBytes, 3'b000}
                              + (cmdRead ? 7'd8 : 7'd0);
                    stateD = HOST_SELECT;
                end
            end
            HOST_SELECT: begin
                if (halfDone) begin
                    stateD = HOST_SHIFT;
                end
            end
            HOST_SHIFT: begin
                if (halfDone) begin
                    sclkD = !sclkQ;
                    if (!sclkQ) begin
                        rxD = {rxQ[6:0], doSync2Q};
                    end else begin
                        txD = {txQ[38:0], 1'b0};
                        bitsLeftD = bitsLeftQ - 7'd1;
                        if (bitsLeftQ == 7'd1) begin
                            stateD = HOST_TAIL;
                        end
                    end
                end
            end
            HOST_TAIL: begin
                if (halfDone) begin
                    csND = 1'b1;
                    gapD = 4'd0;
                    validD = readQ;
                    statusD = readQ ? rxQ : statusQ;
                    stateD = HOST_GAP;
                end
            end
            HOST_GAP: begin
                gapD = gapQ + 4'd1;
                if (gapQ == `DESELECT_CYC - 4'd1) begin
                    stateD = HOST_IDLE;
                end
            end
            default: begin
                stateD = HOST_IDLE;
                csND = 1'b1;
                sclkD = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stateQ <= HOST_IDLE;
            divQ <= 3'd0;
            gapQ <= 4'd0;
            sclkQ <= 1'b0;
            csNQ <= 1'b1;
            txQ <= 40'h00_0000_0000;
            bitsLeftQ <= 7'd0;
            rxQ <= 8'h00;
            readQ <= 1'b0;
            validQ <= 1'b0;
            statusQ <= 8'h00;
            doSync1Q <= 1'b0;
            doSync2Q <= 1'b0;
        end else begin
            stateQ <= stateD;
            divQ <= divD;
            gapQ <= gapD;
            sclkQ <= sclkD;
            csNQ <= csND;
            txQ <= txD;
            bitsLeftQ <= bitsLeftD;
            rxQ <= rxD;
            readQ <= readD;
            validQ <= validD;
            statusQ <= statusD;
            doSync1Q <= link.serialOut;
            doSync2Q <= doSync1Q;
        end
    end

    assign cmdReady = stateQ == HOST_IDLE;
    assign link.sclk = sclkQ;
    assign link.csN = csNQ;
    assign link.serialIn = txQ[39];
    assign statusByte = statusQ;
    assign statusValid = validQ;
endmodule : flash_erase_host
`default_nettype wire

// file: tb/flash_erase_chk.sv
// Concurrent checks on the flash link and the erase sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_erase_chk
    import flash_erase_pkg::*;
#(
    parameter int unsigned SECTOR_CYC = 20,
    parameter int unsigned HALF_BLOCK_CYC = 20,
    parameter int unsigned BLOCK64_CYC = 20,
    parameter int unsigned CHIP_CYC = 20
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sclk,
    input wire logic csN,
    input wire logic serialIn,
    input wire logic serialOutEn,
    input wire logic eraseStart,
    input wire erase_kind_e eraseKind,
    input wire logic eraseDone,
    input wire logic write_in_progress_flag,
    input wire logic write_enable_latch
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [31:0] busyCnt_q, busyCnt_d, wantCyc;
    logic [3:0] sinceCs_q, sinceCs_d;
    always_comb begin
        busyCnt_d = (!rst && write_in_progress_flag) ? busyCnt_q + 32'h1 : '0;
        sinceCs_d = (rst || !csN) ? 4'h0 : sinceCs_q + {3'h0, sinceCs_q != 4'hF};
        case (eraseKind)
            KIND_SECTOR: wantCyc = 32'(SECTOR_CYC);
            KIND_HALF_BLOCK: wantCyc = 32'(HALF_BLOCK_CYC);
            KIND_BLOCK64: wantCyc = 32'(BLOCK64_CYC);
            default: wantCyc = 32'(CHIP_CYC);
        endcase
    end
    always_ff @(posedge clk_sys) begin
        busyCnt_q <= busyCnt_d;
        sinceCs_q <= sinceCs_d;
    end
    chk_sclk_deselected: assert property (csN |-> !sclk)
        else $error("link clock moved while deselected");
    chk_data_sclk_low: assert property (!csN && $changed(serialIn) |-> !sclk)
        else $error("serial data changed while link clock high");
    chk_out_deselected: assert property (csN |-> !serialOutEn)
        else $error("device drives output while deselected");
    chk_start_after_cs: assert property (eraseStart |-> csN && sinceCs_q inside {[4'h2:4'h8]})
        else $error("erase started away from the select rise");
    chk_start_needs_latch: assert property (eraseStart |-> $past(write_enable_latch) && !$past(write_in_progress_flag))
        else $error("erase started without latch or while busy");
    chk_start_sets_busy: assert property (eraseStart |-> write_in_progress_flag ##1 write_in_progress_flag)
        else $error("busy flag not raised at erase start");
    chk_latch_cleared: assert property (eraseStart |-> ##[0:1] !write_enable_latch)
        else $error("write enable latch kept through erase");
    chk_busy_has_cause: assert property ($rose(write_in_progress_flag) |-> eraseStart)
        else $error("busy flag rose without erase start");
    chk_erase_length: assert property ($fell(write_in_progress_flag) |-> busyCnt_q == wantCyc)
        else $error("erase cycle length wrong for its kind");
    chk_done_ends_busy: assert property (eraseDone |-> ##[0:1] !write_in_progress_flag)
        else $error("busy flag stayed high after done");
endmodule : flash_erase_chk
`default_nettype wire

// file: tb/serial_flash_erase_commands_tb.sv
// Self-checking bench for the flash erase host and device pair
`timescale 1ns/1ps
`default_nettype none
`include "flash_erase_cfg.svh"
module serial_flash_erase_commands_tb import flash_erase_pkg::*;;
    localparam int SEC = 400, HALF = 500, BLK = 600, CHIP = 700;
    localparam logic [7:0] OPS [6] = '{`OP_BLOCK64_ERASE, `OP_SECTOR_ERASE_WIDE,
        `OP_HALF_BLOCK_ERASE_WIDE, `OP_BLOCK64_ERASE_WIDE, `OP_CHIP_ERASE_A,
        `OP_CHIP_ERASE_B};
    localparam logic [33:0] WANT [6] = '{{KIND_BLOCK64, 32'h01AB_0000},
        {KIND_SECTOR, 32'h01AB_C000}, {KIND_HALF_BLOCK, 32'h01AB_8000},
        {KIND_BLOCK64, 32'h01AB_0000}, {KIND_CHIP, 32'h0000_0000},
        {KIND_CHIP, 32'h0000_0000}};
    logic clk_sys = 1'b0, rst = 1'b1, cmdValid = 1'b0, cmdRead = 1'b0;
    logic addr4Mode = 1'b0;
    logic [7:0] cmdOp = 8'h00, extAddr = 8'h00;
    logic [31:0] cmdAddr = '0;
    logic [2:0] cmdAddrBytes = 3'd0;
    logic [5:0] prot = 6'h00;
    logic cmdReady, statusValid, eraseStart, eraseDone, busy, latch;
    logic [7:0] statusByte, st;
    logic [31:0] eraseBase;
    erase_kind_e eraseKind;
    logic [33:0] starts[$];
    int badCount = 0, testsRun = 0;
    flash_link_if link();
    flash_erase_device #(.SECTOR_CYC(SEC), .HALF_BLOCK_CYC(HALF),
        .BLOCK64_CYC(BLK), .CHIP_CYC(CHIP)) u_flash_erase_device (
        .clk_sys(clk_sys), .rst(rst), .link(link),
        .protect_complement_bit(prot[5]), .protect_top_bottom_bit(prot[4]),
        .protect_level_bit3(prot[3]), .protect_level_bit2(prot[2]),
        .protect_level_bit1(prot[1]), .protect_level_bit0(prot[0]),
        .addr4Mode(addr4Mode), .extAddr(extAddr), .eraseStart(eraseStart),
        .eraseKind(eraseKind), .eraseBase(eraseBase), .eraseDone(eraseDone),
        .write_in_progress_flag(busy), .write_enable_latch(latch));
    flash_erase_host u_flash_erase_host (.clk_sys(clk_sys), .rst(rst),
        .link(link), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
        .cmdAddr(cmdAddr), .cmdAddrBytes(cmdAddrBytes), .cmdRead(cmdRead),
        .statusByte(statusByte), .statusValid(statusValid));
    flash_erase_chk #(.SECTOR_CYC(SEC), .HALF_BLOCK_CYC(HALF),
        .BLOCK64_CYC(BLK), .CHIP_CYC(CHIP)) u_flash_erase_chk (
        .clk_sys(clk_sys), .rst(rst), .sclk(link.sclk), .csN(link.csN),
        .serialIn(link.serialIn), .serialOutEn(link.serialOutEn),
        .eraseStart(eraseStart), .eraseKind(eraseKind),
        .eraseDone(eraseDone), .write_in_progress_flag(busy),
        .write_enable_latch(latch));
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (eraseStart === 1'b1) starts.push_back({eraseKind, eraseBase});
    end
    task automatic tallyAndFinish();
        if (badCount == 0 && testsRun > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tallyAndFinish
    task automatic check(input string name, input logic [33:0] exp,
                         input logic [33:0] got);
        testsRun++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // Ready is looked at mid-cycle, request launched on the next rising edge
    task automatic send(input logic [7:0] op, input logic [31:0] a,
                        input logic [2:0] nb, input logic rd);
        int n;
        n = 0;
        st = 8'hxx;
        do @(negedge clk_sys); while (cmdReady !== 1'b1 && ++n < 100);
        @(posedge clk_sys);
        cmdOp <= op;
        cmdAddr <= a;
        cmdAddrBytes <= nb;
        cmdRead <= rd;
        cmdValid <= 1'b1;
        @(posedge clk_sys);
        cmdValid <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_sys);
            if (statusValid === 1'b1) st = statusByte;
        end while (cmdReady !== 1'b1 && ++n < 1000);
        if (n >= 1000) check("host_ready", 34'h1, 34'h0);
    endtask : send
    task automatic setcfg(input logic m, input logic [7:0] e,
                          input logic [5:0] p);
        @(posedge clk_sys);
        addr4Mode <= m;
        extAddr <= e;
        prot <= p;
    endtask : setcfg
    task automatic waitIdle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(negedge clk_sys);
            n++;
        end
        check("busy_end", 34'h0, {33'h0, busy});
    endtask : waitIdle
    // Enable, issue one erase, then check that one cycle started when go is set, none when it is clear
    task automatic expectErase(input logic [7:0] op, input logic [31:0] a,
        input logic [2:0] nb, input logic [33:0] want, input logic go);
        send(`OP_WRITE_ENABLE, '0, 3'd0, 1'b0);
        starts.delete();
        send(op, a, nb, 1'b0);
        repeat (8) @(negedge clk_sys);
        check("start_count", {33'h0, go}, 34'(starts.size()));
        if (starts.size() > 0) check("erase_target", want, starts.pop_front());
        waitIdle();
    endtask : expectErase
    initial begin
        repeat (60000) @(posedge clk_sys);
        check("watchdog", 34'h0, 34'h1);
        tallyAndFinish();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        send(`OP_READ_STATUS, '0, 3'd0, 1'b1);
        check("status_reset", 34'h0, {26'h0, st});
        send(`OP_BLOCK64_ERASE, 32'h0001_0000, 3'd3, 1'b0);
        repeat (8) @(negedge clk_sys);
        send(`OP_READ_STATUS, '0, 3'd0, 1'b1);
        check("status_no_latch", 34'h0, {26'h0, st});
        check("start_count", 34'h0, 34'(starts.size()));
        setcfg(1'b0, 8'hA5, 6'h00);
        send(`OP_WRITE_ENABLE, '0, 3'd0, 1'b0);
        send(`OP_READ_STATUS, '0, 3'd0, 1'b1);
        check("status_enabled", 34'h2, {26'h0, st});
        starts.delete();
        send(`OP_BLOCK64_ERASE, 32'h0012_3456, 3'd3, 1'b0);
        send(`OP_READ_STATUS, '0, 3'd0, 1'b1);
        check("status_busy", 34'h1, {26'h0, st});
        check("start_count", 34'h1, 34'(starts.size()));
        check("erase_target", {KIND_BLOCK64, 32'hA512_0000}, starts.pop_front());
        waitIdle();
        for (int i = 0; i < 6; i++) begin
            setcfg(i == 0, 8'h00, 6'h00);
            expectErase(OPS[i], 32'h01AB_CDEF, (i > 3) ? 3'd0 : 3'd4, WANT[i], 1'b1);
        end
        setcfg(1'b1, 8'h00, 6'h00);
        expectErase(`OP_BLOCK64_ERASE, 32'h0003_0000, 3'd3, '0, 1'b0);
        setcfg(1'b0, 8'h00, 6'h00);
        expectErase(`OP_SECTOR_ERASE_WIDE, 32'h0003_0000, 3'd3, '0, 1'b0);
        expectErase(`OP_CHIP_ERASE_A, 32'h0003_0000, 3'd1, '0, 1'b0);
        setcfg(1'b0, 8'h00, 6'b00_0001);
        expectErase(`OP_BLOCK64_ERASE_WIDE, 32'h01FF_1234, 3'd4, '0, 1'b0);
        expectErase(`OP_CHIP_ERASE_B, '0, 3'd0, '0, 1'b0);
        expectErase(`OP_BLOCK64_ERASE_WIDE, 32'h01FE_5678, 3'd4, {KIND_BLOCK64, 32'h01FE_0000}, 1'b1);
        setcfg(1'b0, 8'h00, 6'b10_0001);
        expectErase(`OP_BLOCK64_ERASE_WIDE, 32'h01FE_5678, 3'd4, '0, 1'b0);
        setcfg(1'b0, 8'h00, 6'b01_0001);
        expectErase(`OP_SECTOR_ERASE_WIDE, 32'h0000_1000, 3'd4, '0, 1'b0);
        tallyAndFinish();
    end
endmodule : serial_flash_erase_commands_tb
`default_nettype wire
